// *** core/edg_pkg.sv ***
// package: object indices, field layouts, reset values and timing for encoder diagnostics
package edg_pkg;

   // ----------------------------------------------------------------
   // channel layout
   // ----------------------------------------------------------------
   localparam int          NUM_CH         = 2;
   localparam int          CNT_W          = 16;           // diagnostic counter width
   localparam logic [15:0] IDX_CH_STRIDE  = 16'h0010;     // index step from channel 1 to 2

   // ----------------------------------------------------------------
   // object indices (channel 1; channel 2 adds the stride to all but restore and command)
   // ----------------------------------------------------------------
   localparam logic [15:0] IDX_INPUT      = 16'h6000;     // cyclic input status
   localparam logic [15:0] IDX_INPUT_X    = 16'h6002;     // cyclic input state word
   localparam logic [15:0] IDX_SETTINGS   = 16'h8000;     // encoder settings
   localparam logic [15:0] IDX_DIAG       = 16'ha000;     // diagnosis data
   localparam logic [15:0] IDX_RESTORE    = 16'h1011;     // restore default parameters
   localparam logic [15:0] IDX_COMMAND    = 16'hfb00;     // command object

   // ----------------------------------------------------------------
   // subindices
   // ----------------------------------------------------------------
   localparam logic [7:0]  SI_STATUS_FLAG = 8'h06;
   localparam logic [7:0]  SI_DATA_INVAL  = 8'h0e;
   localparam logic [7:0]  SI_FILT_DIS    = 8'h08;
   localparam logic [7:0]  SI_PLAUS_EN    = 8'h21;
   localparam logic [7:0]  SI_ERR_STATUS  = 8'h05;
   localparam logic [7:0]  SI_PLAUS_CNT   = 8'h13;
   localparam logic [7:0]  SI_LATCH_CNT   = 8'h14;
   localparam logic [7:0]  SI_GATE_CNT    = 8'h15;
   localparam logic [7:0]  SI_ENC_CNT     = 8'h16;
   localparam logic [7:0]  SI_RESTORE_NUM = 8'h00;
   localparam logic [7:0]  SI_RESTORE_TRG = 8'h01;
   localparam logic [7:0]  SI_CMD_REQ     = 8'h01;

   // ----------------------------------------------------------------
   // values and reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] RESTORE_SIG    = 32'h64616f6c;
   localparam logic [31:0] RESTORE_TRG_RST = 32'h00000000;
   localparam logic [7:0]  RESTORE_NUM    = 8'h01;
   localparam logic        PLAUS_EN_RST   = 1'b0;
   localparam logic        FILT_DIS_RST   = 1'b1;
   localparam logic [31:0] CMD_CLR_CH1    = 32'h00000001;
   localparam logic [31:0] CMD_CLR_CH2    = 32'h00000002;
   localparam logic [15:0] TXT_PLAUS      = 16'h8312;
   localparam logic [15:0] TXT_STATUS_OV  = 16'h8315;

   // ----------------------------------------------------------------
   // timing: status input filter defaults to 100 kHz, the core's FILT_CYC parameter can override it
   // ----------------------------------------------------------------
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          STATUS_FILT_NS = 10000;
   localparam int          STATUS_FILT_CYC = (STATUS_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          SFC_W          = $clog2(STATUS_FILT_CYC + 1);

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {BUS_INIT, BUS_PREOP, BUS_SAFEOP, BUS_OP} edg_bus_state_t;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] index;
      logic [7:0]  subindex;
      logic [31:0] wdata;
   } edg_od_req_t;

   typedef struct packed {
      logic        ack;
      logic        err;
      logic [31:0] rdata;
   } edg_od_resp_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] text_code;
      logic        channel;
   } edg_diag_t;

endpackage : edg_pkg

// *** core/edg_diag_core.sv ***
// module: two-channel encoder input diagnostics with object-dictionary access
`timescale 1ns/100ps
module edg_diag_core
   import edg_pkg::*;
#(
   parameter int CH      = NUM_CH,
   parameter int CW      = CNT_W,
   parameter int FILT_CYC = STATUS_FILT_CYC
) (
   // clock and reset
   input  wire logic            clock,
   input  wire logic            reset,
   // encoder side
   input  wire logic [CH-1:0]   enc_a,
   input  wire logic [CH-1:0]   enc_b,
   input  wire logic [CH-1:0]   status_in,
   input  wire logic [CH-1:0]   status_ovr,
   // filter overshoot pulses from the input filters
   input  wire logic [CH-1:0]   enc_filt_ovr,
   input  wire logic [CH-1:0]   latch_filt_ovr,
   input  wire logic [CH-1:0]   gate_filt_ovr,
   // fieldbus state and object access
   input  wire edg_bus_state_t  bus_state,
   input  wire edg_od_req_t     od_req,
   output      edg_od_resp_t    od_resp,
   // indicators and diagnosis
   output      logic [CH-1:0]   status_led_red,
   output      logic [CH-1:0]   input_data_invalid_flag,
   output      edg_diag_t       diagnosis_text_entry,
   output      logic            restore_defaults
);

   // ----------------------------------------------------------------
   // saturating counter step
   // ----------------------------------------------------------------
   function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
      sat_inc = (&v) ? v : v + {{(CW-1){1'b0}}, 1'b1};
   endfunction : sat_inc

   // ----------------------------------------------------------------
   // object address decode
   // ----------------------------------------------------------------
   logic             ch_sel;
   logic [15:0]      base_idx;
   logic             ch_ok;
   logic             wr_restore;
   logic             wr_command;
   logic             restore_hit;
   logic             bus_to_op;
   edg_bus_state_t   bus_state_reg;
   logic [31:0]      restore_trg_reg;

   // channel bit sits in index bit 4; all other channel bits must be clear
   assign ch_sel      = od_req.index[4];
   assign base_idx    = od_req.index & ~IDX_CH_STRIDE;
   assign ch_ok       = (32'(ch_sel) < CH);
   assign wr_restore  = od_req.wr && od_req.index == IDX_RESTORE
                        && od_req.subindex == SI_RESTORE_TRG;
   assign wr_command  = od_req.wr && od_req.index == IDX_COMMAND
                        && od_req.subindex == SI_CMD_REQ;
   assign restore_hit = wr_restore && od_req.wdata == RESTORE_SIG;
   assign bus_to_op   = bus_state_reg == BUS_PREOP && bus_state == BUS_OP;

   // ----------------------------------------------------------------
   // per-channel diagnostics
   // ----------------------------------------------------------------
   logic [CH-1:0]    status_flag;
   logic [CH-1:0]    err_status;
   logic [CH-1:0]    plaus_en;
   logic [CH-1:0]    filt_dis;
   logic [CH-1:0]    plaus_err;
   logic [CH-1:0]    ovr_rise;
   logic [CH-1:0]    pend_plaus;
   logic [CH-1:0]    pend_ovr;
   logic [CH-1:0]    grant_plaus;
   logic [CH-1:0]    grant_ovr;
   logic [CW-1:0]    plaus_cnt [CH];
   logic [CW-1:0]    enc_cnt   [CH];
   logic [CW-1:0]    latch_cnt [CH];
   logic [CW-1:0]    gate_cnt  [CH];

   genvar g;
   generate
      for (g = 0; g < CH; g++) begin : g_ch
         logic [$clog2(FILT_CYC + 1)-1:0] filt_cnt_reg;   // sized from the parameter
         logic             a_reg;
         logic             b_reg;
         logic             trk_valid_reg;
         logic             ovr_reg;
         logic             clr_plaus;
         logic             wr_this;
         logic             bad_step;

         assign wr_this   = od_req.wr && ch_ok && 32'(ch_sel) == g
                            && base_idx == IDX_SETTINGS;
         // both tracks toggling in one sample breaks the 90 degree phase relation
         assign bad_step  = (enc_a[g] != a_reg) && (enc_b[g] != b_reg);
         assign plaus_err[g] = plaus_en[g] && trk_valid_reg && bad_step;
         assign ovr_rise[g]  = status_ovr[g] && !ovr_reg;
         assign clr_plaus = bus_to_op
                            || (wr_command && od_req.wdata == (g == 0 ? CMD_CLR_CH1
                                                                      : CMD_CLR_CH2));

         // status input: new level accepted only after staying put for the filter time
         always_ff @(posedge clock) begin
            if (reset) begin
               filt_cnt_reg   <= '0;
               status_flag[g] <= 1'b1;
            end else if (status_in[g] == status_flag[g]) begin
               filt_cnt_reg   <= '0;
            end else if (32'(filt_cnt_reg) >= FILT_CYC - 1) begin
               filt_cnt_reg   <= '0;
               status_flag[g] <= status_in[g];
            end else begin
               filt_cnt_reg   <= filt_cnt_reg + 1'b1;
            end
         end

         // overvoltage error follows the detector level
         always_ff @(posedge clock) begin
            if (reset) begin
               ovr_reg       <= 1'b0;
               err_status[g] <= 1'b0;
            end else begin
               ovr_reg       <= status_ovr[g];
               err_status[g] <= status_ovr[g];
            end
         end

         // indicator red on a faulty encoder or on overvoltage
         always_ff @(posedge clock) begin
            if (reset) begin
               status_led_red[g] <= 1'b0;
            end else begin
               status_led_red[g] <= !status_flag[g] || status_ovr[g];
            end
         end

         // track history; the first sample after reset has no valid predecessor
         always_ff @(posedge clock) begin
            if (reset) begin
               a_reg         <= 1'b0;
               b_reg         <= 1'b0;
               trk_valid_reg <= 1'b0;
            end else begin
               a_reg         <= enc_a[g];
               b_reg         <= enc_b[g];
               trk_valid_reg <= 1'b1;
            end
         end

         // plausibility counter and data-invalid flag; a new error beats a clear
         always_ff @(posedge clock) begin
            if (reset) begin
               plaus_cnt[g]               <= '0;
               input_data_invalid_flag[g] <= 1'b0;
            end else if (plaus_err[g]) begin
               plaus_cnt[g]               <= clr_plaus ? CW'(1) : sat_inc(plaus_cnt[g]);
               input_data_invalid_flag[g] <= 1'b1;
            end else if (clr_plaus) begin
               plaus_cnt[g]               <= '0;
               input_data_invalid_flag[g] <= 1'b0;
            end
         end

         // filter overshoot counters, one per input group
         always_ff @(posedge clock) begin
            if (reset) begin
               enc_cnt[g]   <= '0;
               latch_cnt[g] <= '0;
               gate_cnt[g]  <= '0;
            end else begin
               if (enc_filt_ovr[g] && !filt_dis[g]) enc_cnt[g] <= sat_inc(enc_cnt[g]);
               if (latch_filt_ovr[g]) latch_cnt[g] <= sat_inc(latch_cnt[g]);
               if (gate_filt_ovr[g])  gate_cnt[g]  <= sat_inc(gate_cnt[g]);
            end
         end

         // settings objects; restore puts them back to delivery values
         always_ff @(posedge clock) begin
            if (reset || restore_hit) begin
               plaus_en[g] <= PLAUS_EN_RST;
               filt_dis[g] <= FILT_DIS_RST;
            end else if (wr_this && od_req.subindex == SI_PLAUS_EN) begin
               plaus_en[g] <= od_req.wdata[0];
            end else if (wr_this && od_req.subindex == SI_FILT_DIS) begin
               filt_dis[g] <= od_req.wdata[0];
            end
         end

         // pending diagnosis entries; the set wins over the grant
         always_ff @(posedge clock) begin
            if (reset) begin
               pend_plaus[g] <= 1'b0;
               pend_ovr[g]   <= 1'b0;
            end else begin
               pend_plaus[g] <= (pend_plaus[g] && !grant_plaus[g]) || plaus_err[g];
               pend_ovr[g]   <= (pend_ovr[g] && !grant_ovr[g]) || ovr_rise[g];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // diagnosis arbiter: one entry per cycle, plausibility first, low channel first
   // ----------------------------------------------------------------
   logic [2*CH-1:0]  pend_all;
   logic [2*CH-1:0]  grant_all;
   logic [2*CH-1:0]  grant_code;
   logic             grant_chan;

   assign pend_all   = {pend_ovr, pend_plaus};
   assign grant_all  = pend_all & (~pend_all + 1'b1);    // lowest set bit
   assign {grant_ovr, grant_plaus} = grant_all;
   assign grant_code = grant_all;
   assign grant_chan = |(grant_plaus & ~CH'(1)) || |(grant_ovr & ~CH'(1));

   // entries wait in the pending bits; a repeat event while its own entry still waits merges into it
   always_ff @(posedge clock) begin
      if (reset) begin
         diagnosis_text_entry <= '0;
      end else begin
         diagnosis_text_entry.valid     <= |grant_code;
         diagnosis_text_entry.text_code <= (|grant_plaus) ? TXT_PLAUS : TXT_STATUS_OV;
         diagnosis_text_entry.channel   <= grant_chan;
      end
   end

   // ----------------------------------------------------------------
   // restore trigger and bus state history
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         restore_trg_reg  <= RESTORE_TRG_RST;
         restore_defaults <= 1'b0;
         bus_state_reg    <= BUS_INIT;
      end else begin
         if (wr_restore) restore_trg_reg <= od_req.wdata;
         restore_defaults <= restore_hit;
         bus_state_reg    <= bus_state;
      end
   end

   // ----------------------------------------------------------------
   // object read multiplexer and access answer
   // ----------------------------------------------------------------
   logic [31:0]      rd_val;
   logic             rd_hit;
   logic             wr_hit;

   always_comb begin
      rd_val = '0;
      rd_hit = 1'b1;
      if (od_req.index == IDX_RESTORE && od_req.subindex == SI_RESTORE_NUM) begin
         rd_val = 32'(RESTORE_NUM);
      end else if (od_req.index == IDX_RESTORE && od_req.subindex == SI_RESTORE_TRG) begin
         rd_val = restore_trg_reg;
      end else if (!ch_ok) begin
         rd_hit = 1'b0;
      end else if (base_idx == IDX_INPUT && od_req.subindex == SI_STATUS_FLAG) begin
         rd_val = 32'(status_flag[ch_sel]);
      end else if (base_idx == IDX_INPUT_X && od_req.subindex == SI_DATA_INVAL) begin
         rd_val = 32'(input_data_invalid_flag[ch_sel]);
      end else if (base_idx == IDX_SETTINGS && od_req.subindex == SI_PLAUS_EN) begin
         rd_val = 32'(plaus_en[ch_sel]);
      end else if (base_idx == IDX_SETTINGS && od_req.subindex == SI_FILT_DIS) begin
         rd_val = 32'(filt_dis[ch_sel]);
      end else if (base_idx == IDX_DIAG && od_req.subindex == SI_ERR_STATUS) begin
         rd_val = 32'(err_status[ch_sel]);
      end else if (base_idx == IDX_DIAG && od_req.subindex == SI_PLAUS_CNT) begin
         rd_val = 32'(plaus_cnt[ch_sel]);
      end else if (base_idx == IDX_DIAG && od_req.subindex == SI_LATCH_CNT) begin
         rd_val = 32'(latch_cnt[ch_sel]);
      end else if (base_idx == IDX_DIAG && od_req.subindex == SI_GATE_CNT) begin
         rd_val = 32'(gate_cnt[ch_sel]);
      end else if (base_idx == IDX_DIAG && od_req.subindex == SI_ENC_CNT) begin
         rd_val = 32'(enc_cnt[ch_sel]);
      end else begin
         rd_hit = 1'b0;
      end
   end

   // writable objects: restore trigger, command request, the two settings
   assign wr_hit = wr_restore || wr_command
                   || (ch_ok && base_idx == IDX_SETTINGS
                       && (od_req.subindex == SI_PLAUS_EN || od_req.subindex == SI_FILT_DIS));

   // answer one cycle after the request; unknown objects answer with err
   always_ff @(posedge clock) begin
      if (reset) begin
         od_resp <= '0;
      end else begin
         od_resp.ack   <= od_req.rd || od_req.wr;
         od_resp.err   <= (od_req.rd && !rd_hit) || (od_req.wr && !wr_hit);
         od_resp.rdata <= (od_req.rd && rd_hit) ? rd_val : '0;
      end
   end

endmodule : edg_diag_core

// *** verification/edg_diag_monitor.sv ***
// checker: port-level properties of the encoder diagnostics block
`timescale 1ns/100ps
module edg_diag_monitor
   import edg_pkg::*;
#(
   parameter int CH = NUM_CH
) (
   // clock and reset
   input wire logic           clock,
   input wire logic           reset,
   // encoder side
   input wire logic [CH-1:0]  enc_a,
   input wire logic [CH-1:0]  enc_b,
   input wire logic [CH-1:0]  status_in,
   input wire logic [CH-1:0]  status_ovr,
   // object bus and outputs
   input wire edg_od_req_t    od_req,
   input wire edg_od_resp_t   od_resp,
   input wire logic [CH-1:0]  status_led_red,
   input wire logic [CH-1:0]  input_data_invalid_flag,
   input wire edg_diag_t      diagnosis_text_entry,
   input wire logic           restore_defaults
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   // signature write decoded once so both restore checks agree
   wire sig_wr = od_req.wr && od_req.index == IDX_RESTORE
                 && od_req.subindex == SI_RESTORE_TRG && od_req.wdata == RESTORE_SIG;

   sequence s_req;
      od_req.rd || od_req.wr;
   endsequence
   sequence s_sig_wr;
      sig_wr;
   endsequence
   // both tracks of channel 1 moved in one sample, one or two samples back
   sequence s_flip_back;
      ($past(enc_a[0]) != $past(enc_a[0], 2) && $past(enc_b[0]) != $past(enc_b[0], 2))
      || ($past(enc_a[0], 2) != $past(enc_a[0], 3) && $past(enc_b[0], 2) != $past(enc_b[0], 3));
   endsequence

   chk_ack_next: assert property (s_req |=> od_resp.ack)
      else $error("object request not answered next cycle");
   chk_no_stray_ack: assert property (!(od_req.rd || od_req.wr) |=> !od_resp.ack)
      else $error("answer without request");
   chk_restore_fires: assert property (s_sig_wr |=> restore_defaults)
      else $error("signature write gave no restore pulse");
   chk_restore_only_sig: assert property (restore_defaults |-> $past(sig_wr))
      else $error("restore pulse without signature write");
   chk_ovr_led: assert property (status_ovr[1] |=> status_led_red[1])
      else $error("overvoltage did not light indicator");
   chk_led_cause: assert property ($rose(status_led_red[0])
         |-> $past(status_ovr[0]) || !$past(status_in[0], 2))
      else $error("indicator lit without fault or overvoltage");
   chk_flag_cause: assert property ($rose(input_data_invalid_flag[0]) |-> s_flip_back)
      else $error("invalid flag set without double track change");
   chk_plaus_entry: assert property (diagnosis_text_entry.valid
         && diagnosis_text_entry.text_code == TXT_PLAUS
         |-> input_data_invalid_flag[diagnosis_text_entry.channel])
      else $error("plausibility entry without invalid flag");
   chk_ovr_entry: assert property (diagnosis_text_entry.valid
         && diagnosis_text_entry.text_code == TXT_STATUS_OV
         |-> status_led_red[diagnosis_text_entry.channel])
      else $error("overvoltage entry without red indicator");
endmodule : edg_diag_monitor

bind edg_diag_core edg_diag_monitor #(.CH(CH)) u_mon (.clock, .reset, .enc_a, .enc_b,
   .status_in, .status_ovr, .od_req, .od_resp, .status_led_red, .input_data_invalid_flag,
   .diagnosis_text_entry, .restore_defaults);

// *** verification/edg_enc_model.sv ***
// model: two-channel quadrature encoder with fault output
`timescale 1ns/100ps
module edg_enc_model
   import edg_pkg::*;
(
   // clock
   input  wire logic         clock,
   // tracks and fault output
   output logic [NUM_CH-1:0] enc_a,
   output logic [NUM_CH-1:0] enc_b,
   output logic [NUM_CH-1:0] status_in
);
   // fault output open at start, which reads as high
   initial begin
      enc_a = '0;
      enc_b = '0;
      status_in = '1;
   end

   // gray order changes one track per step; spacing stays far under filter limits
   task automatic step(input int ch);
      @(posedge clock);
      if (enc_a[ch] == enc_b[ch]) enc_a[ch] <= ~enc_a[ch];
      else enc_b[ch] <= ~enc_b[ch];
      repeat (3) @(posedge clock);
   endtask : step

   // interference: both tracks flip together, only when a test asks for it
   task automatic glitch(input int ch);
      @(posedge clock);
      enc_a[ch] <= ~enc_a[ch];
      enc_b[ch] <= ~enc_b[ch];
   endtask : glitch

   // fault output: low when faulty, high otherwise
   task automatic set_fault(input int ch, input logic faulty);
      @(posedge clock);
      status_in[ch] <= ~faulty;
   endtask : set_fault
endmodule : edg_enc_model

// *** verification/tb.sv ***
// testbench: encoder diagnostics scenarios with self checks
`timescale 1ns/100ps
module tb;
   import edg_pkg::*;
   localparam int  FC = 4;   // short status filter keeps the run brief
   logic           clock, reset;
   logic [1:0]     enc_a, enc_b, status_in, status_ovr;
   logic [1:0]     enc_filt_ovr, latch_filt_ovr, gate_filt_ovr;
   logic [1:0]     status_led_red, input_data_invalid_flag;
   logic           restore_defaults;
   edg_bus_state_t bus_state;
   edg_od_req_t    od_req;
   edg_od_resp_t   od_resp;
   edg_diag_t      diagnosis_text_entry, last_diag;
   int             failures, num_checks, n_diag, n_restore;

   edg_diag_core #(.FILT_CYC(FC)) dut (.clock, .reset, .enc_a, .enc_b, .status_in,
      .status_ovr, .enc_filt_ovr, .latch_filt_ovr, .gate_filt_ovr, .bus_state, .od_req,
      .od_resp, .status_led_red, .input_data_invalid_flag, .diagnosis_text_entry,
      .restore_defaults);
   edg_enc_model enc (.clock, .enc_a, .enc_b, .status_in);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // pulses last one cycle, so they are logged as they pass
   always @(posedge clock) begin
      if (diagnosis_text_entry.valid === 1'b1) begin
         last_diag <= diagnosis_text_entry;
         n_diag++;
      end
      if (restore_defaults === 1'b1) n_restore++;
   end

   function automatic logic [15:0] ix(input logic [15:0] b, input int ch);
      return b + 16'(ch) * IDX_CH_STRIDE;
   endfunction : ix

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // one object access; the answer is judged in the cycle it stands
   task automatic od(input logic w, input logic [15:0] i, input logic [7:0] s,
                     input logic [31:0] wd, input logic xe, input logic [31:0] xd);
      @(posedge clock);
      od_req <= '{rd: ~w, wr: w, index: i, subindex: s, wdata: wd};
      @(posedge clock);
      od_req.rd <= 1'b0;
      od_req.wr <= 1'b0;
      #1;
      chk("ack", 1'b1, od_resp.ack);
      chk("err", xe, od_resp.err);
      if (!w) chk($sformatf("obj %h:%h", i, s), xd, od_resp.rdata);
   endtask : od

   task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] xd);
      od(1'b0, i, s, '0, 1'b0, xd);
   endtask : rd

   task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] wd);
      od(1'b1, i, s, wd, 1'b0, '0);
   endtask : wr

   // k: 0 encoder, 1 latch, 2 gate; n back-to-back overshoots
   task automatic pulse(input int k, input int ch, input int n);
      repeat (n) begin
         @(posedge clock);
         enc_filt_ovr[ch] <= (k == 0);
         latch_filt_ovr[ch] <= (k == 1);
         gate_filt_ovr[ch] <= (k == 2);
      end
      @(posedge clock);
      {enc_filt_ovr, latch_filt_ovr, gate_filt_ovr} <= '0;
   endtask : pulse

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_regs;
      rd(IDX_RESTORE, SI_RESTORE_NUM, RESTORE_NUM);
      rd(IDX_RESTORE, SI_RESTORE_TRG, RESTORE_TRG_RST);
      rd(IDX_SETTINGS, SI_PLAUS_EN, 0);
      rd(IDX_SETTINGS, SI_FILT_DIS, 1);
      rd(IDX_INPUT, SI_STATUS_FLAG, 1);
      chk("led", 2'b00, status_led_red);
      od(1'b0, 16'h7777, 8'h00, '0, 1'b1, '0);
      od(1'b0, IDX_COMMAND, SI_CMD_REQ, '0, 1'b1, '0);
      od(1'b1, IDX_RESTORE, SI_RESTORE_NUM, 32'h00000005, 1'b1, '0);
      rd(IDX_RESTORE, SI_RESTORE_NUM, RESTORE_NUM);
      $display("test regs done");
   endtask : t_regs

   task automatic t_plaus;
      int n;
      for (int ch = 0; ch < 2; ch++) begin
         enc.glitch(ch);
         rd(ix(IDX_DIAG, ch), SI_PLAUS_CNT, 0);
         wr(ix(IDX_SETTINGS, ch), SI_PLAUS_EN, 1);
         enc.step(ch);
         enc.step(ch);
         rd(ix(IDX_DIAG, ch), SI_PLAUS_CNT, 0);
         n = n_diag;
         enc.glitch(ch);
         repeat (3) @(posedge clock);
         rd(ix(IDX_DIAG, ch), SI_PLAUS_CNT, 1);
         rd(ix(IDX_INPUT_X, ch), SI_DATA_INVAL, 1);
         chk("diag code", TXT_PLAUS, last_diag.text_code);
         chk("diag chan", ch, last_diag.channel);
         chk("diag count", n + 1, n_diag);
      end
      wr(IDX_COMMAND, SI_CMD_REQ, CMD_CLR_CH1);
      rd(IDX_DIAG, SI_PLAUS_CNT, 0);
      rd(ix(IDX_DIAG, 1), SI_PLAUS_CNT, 1);
      chk("invalid", 2'b10, input_data_invalid_flag);
      wr(IDX_COMMAND, SI_CMD_REQ, CMD_CLR_CH2);
      rd(ix(IDX_DIAG, 1), SI_PLAUS_CNT, 0);
      enc.glitch(0);
      enc.glitch(0);
      repeat (3) @(posedge clock);
      rd(IDX_DIAG, SI_PLAUS_CNT, 2);
      @(posedge clock) bus_state <= BUS_OP;
      repeat (2) @(posedge clock);
      rd(IDX_DIAG, SI_PLAUS_CNT, 0);
      $display("test plausibility done");
   endtask : t_plaus

   task automatic t_status;
      enc.set_fault(0, 1'b1);
      repeat (FC + 6) @(posedge clock);
      rd(IDX_INPUT, SI_STATUS_FLAG, 0);
      chk("led", 2'b01, status_led_red);
      enc.set_fault(0, 1'b0);
      repeat (FC + 6) @(posedge clock);
      rd(IDX_INPUT, SI_STATUS_FLAG, 1);
      chk("led", 2'b00, status_led_red);
      enc.set_fault(0, 1'b1);
      enc.set_fault(0, 1'b0);
      repeat (FC + 6) @(posedge clock);
      rd(IDX_INPUT, SI_STATUS_FLAG, 1);
      $display("test status done");
   endtask : t_status

   task automatic t_ovr;
      int n;
      n = n_diag;
      @(posedge clock);
      status_ovr <= 2'b10;
      repeat (3) @(posedge clock);
      rd(ix(IDX_DIAG, 1), SI_ERR_STATUS, 1);
      chk("led", 2'b10, status_led_red);
      chk("diag code", TXT_STATUS_OV, last_diag.text_code);
      chk("diag chan", 1, last_diag.channel);
      chk("diag count", n + 1, n_diag);
      @(posedge clock) status_ovr <= 2'b00;
      repeat (3) @(posedge clock);
      rd(ix(IDX_DIAG, 1), SI_ERR_STATUS, 0);
      $display("test overvoltage done");
   endtask : t_ovr

   task automatic t_filt;
      pulse(0, 0, 2);
      rd(IDX_DIAG, SI_ENC_CNT, 0);
      wr(IDX_SETTINGS, SI_FILT_DIS, 0);
      pulse(0, 0, 2);
      rd(IDX_DIAG, SI_ENC_CNT, 2);
      pulse(1, 0, 3);
      rd(IDX_DIAG, SI_LATCH_CNT, 3);
      rd(IDX_DIAG, SI_GATE_CNT, 0);
      pulse(2, 1, 1);
      rd(ix(IDX_DIAG, 1), SI_GATE_CNT, 1);
      pulse(1, 1, 65540);
      rd(ix(IDX_DIAG, 1), SI_LATCH_CNT, 32'h0000ffff);
      $display("test filters done");
   endtask : t_filt

   task automatic t_restore;
      int n;
      n = n_restore;
      wr(IDX_RESTORE, SI_RESTORE_TRG, 32'h64616f6d);
      rd(IDX_RESTORE, SI_RESTORE_TRG, 32'h64616f6d);
      rd(IDX_SETTINGS, SI_FILT_DIS, 0);
      chk("restore count", n, n_restore);
      wr(IDX_RESTORE, SI_RESTORE_TRG, RESTORE_SIG);
      rd(IDX_SETTINGS, SI_FILT_DIS, FILT_DIS_RST);
      rd(ix(IDX_SETTINGS, 1), SI_PLAUS_EN, PLAUS_EN_RST);
      chk("restore count", n + 1, n_restore);
      $display("test restore done");
   endtask : t_restore

   task automatic print_verdict;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict

   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      reset = 1'b1;
      bus_state = BUS_PREOP;
      od_req = '0;
      status_ovr = '0;
      {enc_filt_ovr, latch_filt_ovr, gate_filt_ovr} = '0;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      t_regs;
      t_plaus;
      t_status;
      t_ovr;
      t_filt;
      t_restore;
      print_verdict;
   end

   // the saturation run dominates; the limit leaves a wide margin over it
   initial begin
      repeat (90000) @(posedge clock);
      failures++;
      $display("ERROR watchdog expected done seen timeout");
      print_verdict;
   end
endmodule : tb
